// *** include/conv_ctrl_pkg.sv ***
// Constants and types for the converter track and burst controller
package conv_ctrl_pkg;
    localparam logic [7:0] CTRL_ADDR      = 8'hE8;   // converter_control byte offset
    localparam logic [7:0] CONFIG_ADDR    = 8'hEC;   // converter_config_reg
    localparam logic [7:0] REPEAT_ADDR    = 8'hF0;   // repeat count / burst timing
    localparam logic [7:0] RESULT_ADDR    = 8'hF4;   // result high:low
    localparam logic [7:0] WINDOW_ADDR    = 8'hF8;   // upper[31:16], lower[15:0]
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_RESET   = 8'hF8;
    localparam int         EN_BIT         = 7;
    localparam int         BURST_BIT      = 6;
    localparam int         DONE_BIT       = 5;
    localparam int         BUSY_BIT       = 4;
    localparam int         WIN_BIT        = 3;
    localparam int         BYTE_MODE_BIT  = 2;
    localparam int         LP_TRACK_BIT   = 1;
    localparam int         GAIN_BIT       = 0;
    localparam logic [2:0] SRC_SOFTWARE   = 3'h0;
    localparam logic [2:0] SRC_TIMER0     = 3'h1;
    localparam logic [2:0] SRC_TIMER2     = 3'h2;
    localparam logic [2:0] SRC_TIMER3     = 3'h3;
    localparam logic [3:0] LP_TRACK_CLKS  = 4'h3;
    localparam logic [3:0] BITS_10        = 4'hA;
    localparam logic [3:0] BITS_8         = 4'h8;
    localparam logic [5:0] POWERUP_RESET  = 6'h0F;
    localparam logic [5:0] TRACK_RESET    = 6'h1E;
    typedef enum logic [2:0] {ST_IDLE, ST_POWERUP, ST_TRACK, ST_LPTRACK, ST_CONVERT} conv_state_t;
endpackage

// *** design/conv_track_burst_ctrl.sv ***
// Converter tracking, burst and start control with APB register access
`timescale 1ns/1ps
module conv_track_burst_ctrl
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer0_ovf,
    input  wire logic        timer2_ovf,
    input  wire logic        timer3_ovf,
    input  wire logic        ext_convert_start_pin,
    input  wire logic        sar_clk_tick,
    input  wire logic        sar_bit_in,
    output logic             sar_power_on,
    output logic             sar_track,
    output logic             sar_convert,
    output logic             gain_select_out,
    output logic             burst_clk_run
);
    import conv_ctrl_pkg::*;

    logic [7:0]  ctrl_q;
    logic [7:0]  cfg_q;
    logic [2:0]  rpt_q;
    logic [5:0]  pwr_time_q;
    logic [5:0]  trk_time_q;
    logic [15:0] result_q;
    logic [15:0] acc_q;
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic [9:0]  shift_q;
    conv_state_t state_q;
    logic [5:0]  cnt_q;
    logic [3:0]  bit_q;
    logic [6:0]  done_cnt_q;
    logic        busy_q;
    logic [3:0]  sync0_q;
    logic [3:0]  sync1_q;
    logic [3:0]  sync2_q;
    logic        tick_q;
    logic        start_ev;
    logic        sw_start;
    logic        conv_end;
    logic        last_conv;
    logic        clr_done;
    logic        clr_win;
    logic        win_hit;
    logic [15:0] acc_sum;
    logic        wr_en;
    logic        rd_en;

    // Repeat code to number of conversions
    function automatic logic [6:0] rpt_count(input logic [2:0] code);
        case (code)
            3'h1:    rpt_count = 7'h04;
            3'h2:    rpt_count = 7'h08;
            3'h3:    rpt_count = 7'h10;
            3'h4:    rpt_count = 7'h20;
            3'h5:    rpt_count = 7'h40;
            default: rpt_count = 7'h01;
        endcase
    endfunction

    // Address decode shared by read and write
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == CTRL_ADDR) || (a == CONFIG_ADDR) || (a == REPEAT_ADDR) ||
                 (a == RESULT_ADDR) || (a == WINDOW_ADDR);
    endfunction

    assign wr_en = psel && penable && pwrite && mapped(paddr);
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync0_q <= 4'h0;
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            tick_q  <= 1'b0;
        end else begin
            sync0_q <= {ext_convert_start_pin, timer3_ovf, timer2_ovf, timer0_ovf};
            sync1_q <= sync0_q;
            sync2_q <= sync1_q;
            tick_q  <= sar_clk_tick;
        end
    end

    // software start only from source 000
    assign sw_start = wr_en && (paddr == CTRL_ADDR) && pwdata[BUSY_BIT] &&
                      (ctrl_q[2:0] == SRC_SOFTWARE);

    always_comb begin
        case (ctrl_q[2:0])
            SRC_SOFTWARE: start_ev = sw_start;
            SRC_TIMER0:   start_ev = sync1_q[0] && !sync2_q[0];
            SRC_TIMER2:   start_ev = sync1_q[1] && !sync2_q[1];
            SRC_TIMER3:   start_ev = sync1_q[2] && !sync2_q[2];
            default:      start_ev = sync1_q[3] && !sync2_q[3];
        endcase
    end

    // conversion ends after 8 or 10 SAR bits
    assign conv_end  = (state_q == ST_CONVERT) && tick_q && sar_convert && // Comparator valid only once converting
                       (bit_q == (cfg_q[BYTE_MODE_BIT] ? BITS_8 - 4'h1 : BITS_10 - 4'h1));
    // burst continues internally until repeat count reached, except with the pin source
    assign last_conv = (done_cnt_q + 7'h01) >= rpt_count(rpt_q);
    assign acc_sum   = acc_q + {6'h00, cfg_q[BYTE_MODE_BIT] ? {shift_q[6:0], sar_bit_in, 2'b00}
                                                             : {shift_q[8:0], sar_bit_in}};

    // Sequencer: power-up, track, low-power track, convert
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q   <= 6'h00;
            bit_q   <= 4'h0;
            shift_q <= 10'h000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_ev && ctrl_q[EN_BIT] && !ctrl_q[BURST_BIT]) begin
                        state_q <= (cfg_q[LP_TRACK_BIT] && !ctrl_q[2]) ? ST_LPTRACK : ST_CONVERT;
                        cnt_q   <= 6'h00;
                        bit_q   <= 4'h0;
                    end else if (start_ev && ctrl_q[BURST_BIT]) begin
                        state_q <= ctrl_q[EN_BIT] ? ST_TRACK : ST_POWERUP;
                        cnt_q   <= 6'h00;
                    end
                end
                ST_POWERUP: if (tick_q) begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q >= pwr_time_q) begin
                        state_q <= ST_TRACK;
                        cnt_q   <= 6'h00;
                    end
                end
                // burst track time then optional extra clocks
                ST_TRACK: if (tick_q) begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q >= trk_time_q) begin
                        state_q <= cfg_q[LP_TRACK_BIT] ? ST_LPTRACK : ST_CONVERT;
                        cnt_q   <= 6'h00;
                        bit_q   <= 4'h0;
                    end
                end
                ST_LPTRACK: if (tick_q) begin
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == {2'h0, LP_TRACK_CLKS - 4'h1}) begin
                        state_q <= ST_CONVERT;
                        bit_q   <= 4'h0;
                    end
                end
                ST_CONVERT: if (tick_q && sar_convert) begin
                    shift_q <= {shift_q[8:0], sar_bit_in};
                    bit_q   <= bit_q + 4'h1;
                    if (conv_end) begin
                        // pin source gives one conversion per edge
                        if (ctrl_q[BURST_BIT] && !last_conv && !ctrl_q[2]) begin
                            state_q <= ST_TRACK;
                            cnt_q   <= 6'h00;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // accumulate until repeat count, then publish result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q      <= 16'h0000;
            done_cnt_q <= 7'h00;
            result_q   <= 16'h0000;
        end else if (conv_end) begin
            if (last_conv) begin
                acc_q      <= 16'h0000;
                done_cnt_q <= 7'h00;
                result_q   <= acc_sum;   // low bits zero in byte mode
            end else begin
                acc_q      <= acc_sum;
                done_cnt_q <= done_cnt_q + 7'h01;
            end
        end
    end

    // window compare on the completed result only
    assign win_hit  = conv_end && last_conv && (acc_sum <= upper_q) && (acc_sum >= lower_q);
    assign clr_done = wr_en && (paddr == CTRL_ADDR) && !pwdata[DONE_BIT];
    assign clr_win  = wr_en && (paddr == CTRL_ADDR) && !pwdata[WIN_BIT];

    // busy high from start until last conversion ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (conv_end && last_conv) begin
            busy_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_ev && (ctrl_q[EN_BIT] || ctrl_q[BURST_BIT])) begin
            busy_q <= 1'b1;
        end
    end

    // Control register; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wr_en && paddr == CTRL_ADDR) begin
                ctrl_q[EN_BIT]    <= pwdata[EN_BIT];   // enable bit
                ctrl_q[BURST_BIT] <= pwdata[BURST_BIT];
                ctrl_q[2:0]       <= pwdata[2:0];
            end
            if (conv_end && last_conv)
                ctrl_q[DONE_BIT] <= 1'b1;
            else if (clr_done)
                ctrl_q[DONE_BIT] <= 1'b0;
            if (win_hit)
                ctrl_q[WIN_BIT] <= 1'b1;
            else if (clr_win)
                ctrl_q[WIN_BIT] <= 1'b0;
        end
    end

    // Config, repeat, timing and window bound registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q      <= CONFIG_RESET;
            rpt_q      <= 3'h0;
            pwr_time_q <= POWERUP_RESET;
            trk_time_q <= TRACK_RESET;
            upper_q    <= 16'hFFFF;
            lower_q    <= 16'h0000;
        end else if (wr_en) begin
            if (paddr == CONFIG_ADDR)
                cfg_q <= pwdata[7:0];
            if (paddr == REPEAT_ADDR) begin
                // reserved codes fall back to 000
                rpt_q      <= (pwdata[2:0] > 3'h5) ? 3'h0 : pwdata[2:0];
                pwr_time_q <= pwdata[13:8];
                trk_time_q <= pwdata[21:16];
            end
            if (paddr == WINDOW_ADDR) begin
                upper_q <= pwdata[31:16];
                lower_q <= pwdata[15:0];
            end
        end
    end

    // APB read data, zero wait states, error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (rd_en) begin
                case (paddr)
                    CTRL_ADDR:   prdata <= {24'h0, ctrl_q[7:5], busy_q, ctrl_q[3:0]};
                    CONFIG_ADDR: prdata <= {24'h0, cfg_q};
                    REPEAT_ADDR: prdata <= {10'h0, trk_time_q, 2'h0, pwr_time_q, 5'h0, rpt_q};
                    RESULT_ADDR: prdata <= {16'h0, result_q};
                    WINDOW_ADDR: prdata <= {upper_q, lower_q};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Analog front-end controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_power_on    <= 1'b0;
            sar_track       <= 1'b0;
            sar_convert     <= 1'b0;
            gain_select_out <= 1'b0;
            burst_clk_run   <= 1'b0;
        end else begin
            // burst with enable 0 powers down when idle
            sar_power_on    <= ctrl_q[EN_BIT] || (state_q != ST_IDLE);
            // continuous tracking; pin-low tracking in lp mode with the pin source only
            sar_track       <= (state_q == ST_TRACK) || (state_q == ST_LPTRACK) ||
                               (state_q == ST_IDLE && ctrl_q[EN_BIT] && !ctrl_q[BURST_BIT] &&
                                (!cfg_q[LP_TRACK_BIT] || (ctrl_q[2] && !sync2_q[3])));
            sar_convert     <= (state_q == ST_CONVERT);
            gain_select_out <= cfg_q[GAIN_BIT];
            // burst clock runs on its own in burst mode while the sequencer is out of idle, so it stops between pin-source conversions
            burst_clk_run   <= ctrl_q[BURST_BIT] && (state_q != ST_IDLE);
        end
    end

    chk_done_after_end: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q[DONE_BIT]) |-> $past(conv_end && last_conv))
        else $error("done flag rose without completed repeat count");
    chk_busy_fall_done: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(busy_q) |-> ctrl_q[DONE_BIT])
        else $error("busy fell without done flag");
    chk_sw_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CTRL_ADDR && pwdata[BUSY_BIT] && ctrl_q[2:0] != SRC_SOFTWARE &&
         state_q == ST_IDLE && !(|(sync1_q & ~sync2_q))) |=> state_q == ST_IDLE)
        else $error("start without proper source");
    // three clock track in low-power mode
    chk_lp_track_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(state_q == ST_LPTRACK) |-> cnt_q == {2'h0, LP_TRACK_CLKS})
        else $error("low-power tracking left early");
    chk_disabled_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && !ctrl_q[EN_BIT] && !ctrl_q[BURST_BIT]) |=> state_q == ST_IDLE)
        else $error("disabled converter started");
    chk_byte_mode_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_end && last_conv && cfg_q[BYTE_MODE_BIT] && rpt_q == 3'h0) |=> result_q[1:0] == 2'h0)
        else $error("byte mode result low bits not zero");
    chk_window_after: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q[WIN_BIT]) |-> $past(conv_end && last_conv))
        else $error("window flag without completed result");
    chk_burst_powerup: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && start_ev && ctrl_q[BURST_BIT] && !ctrl_q[EN_BIT]) |=> state_q == ST_POWERUP)
        else $error("burst skipped power-up");
    cov_burst_done: cover property (@(posedge pclk) ctrl_q[BURST_BIT] && conv_end && last_conv);
    cov_lp_track:   cover property (@(posedge pclk) state_q == ST_LPTRACK);
    cov_win_hit:    cover property (@(posedge pclk) win_hit);
endmodule

// *** tb/sar_core_model.sv ***
// Behavioural analog SAR core: tick source and comparator bit
`timescale 1ns/1ps
module sar_core_model #(
    parameter int TICK_DIV = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sar_convert,
    input  wire logic bit_level,
    output logic      sar_clk_tick,
    output logic      sar_bit_in
);
    int   div_q;
    logic junk_q;
    // Free-running SAR clock, one pulse every TICK_DIV cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q        <= 0;
            sar_clk_tick <= 1'b0;
        end else begin
            div_q        <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            sar_clk_tick <= (div_q == 0);
        end
    end
    // Toggling pattern while the comparator output is not valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_q <= 1'b0;
        end else begin
            junk_q <= ~junk_q;
        end
    end
    // Comparator answers with the analog level only while converting
    assign sar_bit_in = sar_convert ? bit_level : junk_q;
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the converter track and burst controller
`timescale 1ns/1ps
module testbench;
    import conv_ctrl_pkg::*;
    localparam int SAR_DIV = 3;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, cur_ctl;
    logic        t0, t2, t3, pin, tick, sbit, lvl, b8, g, lp;
    logic        pwr_on, trk, cnv, gain_o, brun;
    int          err_count, num_checks, cyc, cnv_n, cnv_0, nb;

    conv_track_burst_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_ovf(t0), .timer2_ovf(t2), .timer3_ovf(t3),
        .ext_convert_start_pin(pin), .sar_clk_tick(tick), .sar_bit_in(sbit), .sar_power_on(pwr_on),
        .sar_track(trk), .sar_convert(cnv), .gain_select_out(gain_o), .burst_clk_run(brun));
    sar_core_model #(.TICK_DIV(SAR_DIV)) core_u (.pclk(pclk), .presetn(presetn), .sar_convert(cnv),
        .bit_level(lvl), .sar_clk_tick(tick), .sar_bit_in(sbit));

    // Cycles with the convert output high
    always @(posedge pclk) cnv_n <= cnv_n + int'(cnv);

    // Clock at 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Hang guard
    initial begin
        cyc = 0;
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc > 60000) begin
                err_count++;
                final_report();
            end
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_pin(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Accumulated code for a constant comparator level
    function automatic logic [31:0] exp_res(input logic l, input logic m8, input int n);
        return l ? (m8 ? 32'h3FC : 32'h3FF) * 32'(n) : 32'h0;
    endfunction

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd   = prdata;
        rerr = pslverr;
        check_reg("apb wait", 32'h1, 32'(n));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Control write; zero flag bits clear done and window
    task automatic setctl(input logic en, input logic bu, input logic [2:0] src);
        cur_ctl = {24'h0, en, bu, 3'b000, src};
        apb(1'b1, CTRL_ADDR, cur_ctl);
    endtask

    task automatic fire(input int s);
        if (s == 0) begin
            apb(1'b1, CTRL_ADDR, cur_ctl | (32'h1 << BUSY_BIT));
        end else begin
            @(posedge pclk);
            t0  <= (s == 1);
            t2  <= (s == 2);
            t3  <= (s == 3);
            pin <= (s > 3);
            repeat (3) @(posedge pclk);
            {t0, t2, t3, pin} <= 4'h0;
        end
        repeat (4) @(posedge pclk);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, CTRL_ADDR, 32'h0);
            n++;
        end while (rd[DONE_BIT] !== 1'b1 && n < 3000);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, t0, t2, t3, pin, lvl} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        cur_ctl = 32'h0;
        err_count = 0;
        num_checks = 0;
        void'($urandom(32'h402a));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_ADDR, 32'h0);
        check_reg("ctrl reset", {24'h0, CTRL_RESET}, rd);
        apb(1'b0, CONFIG_ADDR, 32'h0);
        check_reg("config reset", {24'h0, CONFIG_RESET}, rd);
        apb(1'b0, REPEAT_ADDR, 32'h0);
        check_reg("repeat reset", {10'h0, TRACK_RESET, 2'h0, POWERUP_RESET, 8'h0}, rd);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        check_pin("unmapped err", 1'b1, rerr);
        apb(1'b0, 8'h00, 32'h0);
        check_reg("unmapped read", 32'h0, rd);
        check_pin("shutdown power", 1'b0, pwr_on);
        $display("test reset_defaults done");
        for (int s = 0; s < 5; s++) begin
            b8 = 1'($urandom_range(0, 1));
            g = 1'($urandom_range(0, 1));
            lvl <= 1'($urandom_range(0, 1));
            lp = 1'($urandom_range(0, 1));
            nb = (b8 ? 8 : 10) * SAR_DIV;
            apb(1'b1, CONFIG_ADDR, {29'h0, b8, lp, g});
            setctl(1'b1, 1'b0, 3'(s));
            check_pin("gain out", g, gain_o);
            cnv_0 = cnv_n;
            fire(s);
            wait_done();
            check_pin("convert length", 1'b1, 1'((cnv_n - cnv_0) inside {[nb - 1 : nb + 1]}));
            check_pin("idle track", 1'(!lp || s == 4), trk);
            check_pin("done flag", 1'b1, rd[DONE_BIT]);
            check_pin("busy clear", 1'b0, rd[BUSY_BIT]);
            apb(1'b0, RESULT_ADDR, 32'h0);
            check_reg("result", exp_res(lvl, b8, 1), rd);
        end
        $display("test single_sources done");
        setctl(1'b1, 1'b0, SRC_TIMER0);
        fire(0);
        repeat (200) @(posedge pclk);
        apb(1'b0, CTRL_ADDR, 32'h0);
        check_pin("no soft start", 1'b0, rd[DONE_BIT]);
        $display("test busy_ignored done");
        lvl <= 1'b1;
        apb(1'b1, CONFIG_ADDR, 32'h0);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, WINDOW_ADDR, {16'h3FE + 16'(k), 16'h3FF});
            setctl(1'b1, 1'b0, SRC_SOFTWARE);
            fire(0);
            wait_done();
            apb(1'b0, CTRL_ADDR, 32'h0);
            check_pin("window flag", 1'(k), rd[WIN_BIT]);
        end
        $display("test window done");
        apb(1'b1, REPEAT_ADDR, 32'h0002_0201);
        setctl(1'b0, 1'b1, 3'h4);
        for (int e = 0; e < 4; e++) begin
            fire(4);
            repeat (150) @(posedge pclk);
            apb(1'b0, CTRL_ADDR, 32'h0);
            check_pin("pin burst done", 1'(e == 3), rd[DONE_BIT]);
        end
        check_pin("early window", 1'b0, rd[WIN_BIT]);
        apb(1'b0, RESULT_ADDR, 32'h0);
        check_reg("pin burst sum", exp_res(1'b1, 1'b0, 4), rd);
        $display("test pin_burst done");
        for (int c = 0; c < 6; c++) begin
            apb(1'b1, REPEAT_ADDR, 32'h0002_0200 | 32'(c));
            setctl(1'(c % 2), 1'b1, SRC_SOFTWARE);
            fire(0);
            check_pin("burst clock run", 1'b1, brun);
            wait_done();
            check_pin("burst done", 1'b1, rd[DONE_BIT]);
            apb(1'b0, RESULT_ADDR, 32'h0);
            check_reg("burst sum", exp_res(1'b1, 1'b0, c == 0 ? 1 : 2 << c), rd);
            repeat (8) @(posedge pclk);
            check_pin("idle power", 1'(c % 2), pwr_on);
            check_pin("burst clock stop", 1'b0, brun);
        end
        $display("test burst_counts done");
        final_report();
    end
endmodule
